// ===== cap_sense_counters.sv
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ns
`include "csc_params.svh"
// How it works
// - Charge mode counts, captures on comparator trip.
// - Relax one: two separate 8-bit counters.
// - Interval of 256 or selectable clocks.
// - Overflow flag when relax count exceeds 255.
// - Relax two: 6-bit interval, 16-bit result.
// - 6-bit timer raises interrupt at end.
// - Sequence length selectable 8 or 12.
// - Prescaler gives clock divided by powers of two.
// - Sigma-delta counts need enable and mode bit.
// - Count while synced comparator and start high.
// - Hold count while comparator low.
// - Resume when comparator returns, start high.
// - Start low stops counting for good.
// - Result equals comparator-high cycles in interval.
// - Disabled holds counters reset; enable starts.
module cap_sense_counters (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end and timers, synchronous except the comparator.
  input wire csc_pkg::csc_sense_t sense,
  // Outputs.
  output logic prs_out,
  output logic irq
);
  logic [7:0] ctrl_r;
  logic [7:0] cfg_r;
  logic [5:0] timer_r;
  logic [2:0] status_r;
  logic [2:0] mask_r;
  logic [15:0] cnt_r;
  logic [15:0] result_r;
  logic [7:0] relax_cnt_r;
  logic [5:0] six_r;
  logic ovf_r;
  logic cmp_s1_r;
  logic cmp_s2_r;
  logic relax_d_r;
  logic started_r;
  logic [11:0] prs_r;
  logic [15:0] prs_cnt_r;
  csc_pkg::csc_state_t state_r;
  logic en;
  logic sd;
  logic relax_rise;
  logic capture;
  logic tc_evt;
  logic prs_tick;
  logic wr;
  logic rd;
  logic [7:0] ival;
  csc_pkg::csc_mode_t mode;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  assign en = ctrl_r[`CSC_CTRL_EN];
  assign sd = ctrl_r[`CSC_CTRL_SD];
  assign mode = csc_pkg::csc_mode_t'(ctrl_r[`CSC_CTRL_MODE_LO +: 2]);
  assign ival = cfg_r; // Interval for relax one: 0 means 256 clocks.
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign pready = 1'b1;
  assign relax_rise = sense.relax && !relax_d_r;

  csc_prescaler #(
    .SEL_W(4)
  ) u_pre (
    .clk(clk),
    .rst_n(rst_n),
    .sel(ctrl_r[7:4]),
    .tick(prs_tick)
  );

  // Comparator two-flop synchronizer.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      relax_d_r <= 1'b0;
    end else begin
      cmp_s1_r <= sense.cmp;
      cmp_s2_r <= cmp_s1_r;
      relax_d_r <= sense.relax;
    end
  end

  // Register writes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `CSC_CTRL_RST;
      cfg_r <= `CSC_CFG_RST;
      timer_r <= `CSC_TIMER_RST;
      mask_r <= `CSC_MASK_RST;
    end else if (wr) begin
      if (hit(paddr, `CSC_OFF_CTRL)) begin
        ctrl_r <= pwdata[7:0];
      end else if (hit(paddr, `CSC_OFF_CFG)) begin
        cfg_r <= pwdata[7:0];
      end else if (hit(paddr, `CSC_OFF_TIMER)) begin
        timer_r <= pwdata[5:0];
      end else if (hit(paddr, `CSC_OFF_MASK)) begin
        mask_r <= pwdata[2:0];
      end
    end
  end

  // Capture decision per mode.
  always_comb begin
    capture = 1'b0;
    tc_evt = 1'b0;
    if (state_r == csc_pkg::CSC_S_RUN) begin
      if (sd) begin
        capture = started_r && !sense.start;
      end else begin
        case (mode)
          csc_pkg::CSC_M_CHARGE: capture = cmp_s2_r;
          csc_pkg::CSC_M_RELAX1: capture = (cnt_r[7:0] == ival - 8'h01);
          csc_pkg::CSC_M_RELAX2: capture = relax_rise && (six_r == 6'h00);
          default: tc_evt = (six_r == 6'h00);
        endcase
      end
    end
  end

  // Measurement state and counters.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= csc_pkg::CSC_S_IDLE;
      cnt_r <= 16'h0000;
      relax_cnt_r <= 8'h00;
      six_r <= 6'h00;
      ovf_r <= 1'b0;
      started_r <= 1'b0;
      result_r <= 16'h0000;
    end else if (!en) begin
      state_r <= csc_pkg::CSC_S_IDLE;
      cnt_r <= 16'h0000;
      relax_cnt_r <= 8'h00;
      six_r <= timer_r;
      ovf_r <= 1'b0;
      started_r <= 1'b0;
    end else begin
      case (state_r)
        csc_pkg::CSC_S_IDLE: begin
          state_r <= csc_pkg::CSC_S_RUN;
        end
        csc_pkg::CSC_S_RUN: begin
          if (capture || tc_evt) begin
            state_r <= csc_pkg::CSC_S_DONE;
            if (mode == csc_pkg::CSC_M_RELAX1 && !sd) begin
              result_r <= {8'h00, relax_cnt_r + {7'h00, relax_rise}};
            end else begin
              result_r <= cnt_r;
            end
          end else if (sd) begin
            if (sense.start) begin
              started_r <= 1'b1;
            end
            if (cmp_s2_r && sense.start) begin
              cnt_r <= cnt_r + 16'h0001;
            end
          end else begin
            cnt_r <= cnt_r + 16'h0001;
            if (mode == csc_pkg::CSC_M_RELAX1) begin
              cnt_r[15:8] <= 8'h00;
              if (relax_rise) begin
                relax_cnt_r <= relax_cnt_r + 8'h01;
                if (relax_cnt_r == 8'hff) begin
                  ovf_r <= 1'b1;
                end
              end
            end
            if ((mode == csc_pkg::CSC_M_RELAX2 && relax_rise) ||
                mode == csc_pkg::CSC_M_SUCCAPP) begin
              six_r <= six_r - 6'h01;
            end
          end
        end
        default: begin
          state_r <= csc_pkg::CSC_S_DONE;
        end
      endcase
    end
  end

  // Sequence generator, free running on prescaled ticks.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prs_r <= `CSC_PRS12_SEED;
    end else if (prs_tick) begin
      if (cfg_r[7]) begin
        prs_r <= {prs_r[10:0], ^(prs_r & `CSC_PRS12_TAPS)};
      end else begin
        prs_r <= {4'h0, prs_r[6:0], ^(prs_r[7:0] & `CSC_PRS8_TAPS)};
      end
    end
  end
  assign prs_out = cfg_r[7] ? prs_r[11] : prs_r[7];

  logic [2:0] st_clr;
  logic [2:0] st_set;

  // Events and firmware clears of the status bits.
  always_comb begin
    st_clr = (wr && hit(paddr, `CSC_OFF_STATUS)) ? pwdata[2:0] : 3'h0;
    st_set = 3'h0;
    st_set[`CSC_ST_DONE] = en && state_r == csc_pkg::CSC_S_RUN && capture;
    st_set[`CSC_ST_TC] = en && state_r == csc_pkg::CSC_S_RUN && tc_evt;
    st_set[`CSC_ST_OVF] = en && relax_rise && relax_cnt_r == 8'hff;
  end

  // Sticky status, cleared by writing one; an event in the same cycle wins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= 3'h0;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end
  assign irq = |(status_r & mask_r);

  // Read mux.
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (hit(paddr, `CSC_OFF_CTRL)) begin
      prdata = {24'h0, ctrl_r};
    end else if (hit(paddr, `CSC_OFF_CFG)) begin
      prdata = {24'h0, cfg_r};
    end else if (hit(paddr, `CSC_OFF_TIMER)) begin
      prdata = {26'h0, timer_r};
    end else if (hit(paddr, `CSC_OFF_RESULT)) begin
      prdata = {15'h0, ovf_r, result_r};
    end else if (hit(paddr, `CSC_OFF_STATUS)) begin
      prdata = {29'h0, status_r};
    end else if (hit(paddr, `CSC_OFF_MASK)) begin
      prdata = {29'h0, mask_r};
    end else begin
      pslverr = rd || (psel && pwrite);
    end
  end

  a_sd_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (en && state_r == csc_pkg::CSC_S_RUN && sd && !capture && !cmp_s2_r) |=> $stable(cnt_r))
    else $error("count moved with comparator low");
  a_sd_count: assert property (@(posedge clk) disable iff (!rst_n)
    (en && sd && state_r == csc_pkg::CSC_S_RUN && !capture && cmp_s2_r && sense.start)
    |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("count did not step");
  a_dis_clear: assert property (@(posedge clk) disable iff (!rst_n)
    !en |=> cnt_r == 16'h0000 && state_r == csc_pkg::CSC_S_IDLE)
    else $error("disabled counter not reset");
  a_done_stable: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == csc_pkg::CSC_S_DONE && en) |=> $stable(result_r))
    else $error("result changed after end");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    irq == |(status_r & mask_r) && (status_r[0] || !$rose(status_r[0]) || !$past(en) || en))
    else $error("irq mismatch");
  a_ovf_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (en && relax_rise && relax_cnt_r == 8'hff) |=> status_r[`CSC_ST_OVF])
    else $error("overflow not flagged");
  a_stop_final: assert property (@(posedge clk) disable iff (!rst_n)
    (en && sd && state_r == csc_pkg::CSC_S_DONE) |=> state_r == csc_pkg::CSC_S_DONE)
    else $error("counting resumed after stop");
  a_sync_path: assert property (@(posedge clk) disable iff (!rst_n)
    cmp_s2_r == $past(sense.cmp, 2) || $past(!rst_n, 2))
    else $error("sync depth wrong");
  // Per-mode end of measurement and capture.
  a_charge_cap: assert property (@(posedge clk) disable iff (!rst_n)
    (en && !sd && mode == csc_pkg::CSC_M_CHARGE && state_r == csc_pkg::CSC_S_RUN && cmp_s2_r)
    |=> state_r == csc_pkg::CSC_S_DONE && result_r == $past(cnt_r))
    else $error("charge trip not captured");
  a_relax1_high: assert property (@(posedge clk) disable iff (!rst_n)
    (en && !sd && mode == csc_pkg::CSC_M_RELAX1 && state_r == csc_pkg::CSC_S_RUN)
    |=> cnt_r[15:8] == 8'h00)
    else $error("interval counter not kept to eight bits");
  a_relax1_end: assert property (@(posedge clk) disable iff (!rst_n)
    (en && !sd && mode == csc_pkg::CSC_M_RELAX1 && state_r == csc_pkg::CSC_S_RUN &&
    cnt_r[7:0] == ival - 8'h01) |=> state_r == csc_pkg::CSC_S_DONE)
    else $error("interval end missed");
  a_relax2_end: assert property (@(posedge clk) disable iff (!rst_n)
    (en && !sd && mode == csc_pkg::CSC_M_RELAX2 && state_r == csc_pkg::CSC_S_RUN &&
    relax_rise && six_r == 6'h00) |=> result_r == $past(cnt_r))
    else $error("long count not captured");
  a_tc_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (en && !sd && mode == csc_pkg::CSC_M_SUCCAPP && state_r == csc_pkg::CSC_S_RUN &&
    six_r == 6'h00) |=> status_r[`CSC_ST_TC])
    else $error("timer end not flagged");
  // Sequence generator and prescaler.
  a_prs_short: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg_r[7] && prs_tick) |=> prs_r[11:8] == 4'h0)
    else $error("short sequence uses upper bits");
  a_tick_full: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_r[7:4] == 4'h0) |-> prs_tick)
    else $error("undivided tick missing");
  // Sigma-delta end and enable sequencing.
  a_sd_result: assert property (@(posedge clk) disable iff (!rst_n)
    (en && sd && state_r == csc_pkg::CSC_S_RUN && capture)
    |=> state_r == csc_pkg::CSC_S_DONE && result_r == $past(cnt_r))
    else $error("sigma-delta result not captured");
  a_stop_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (en && sd && state_r == csc_pkg::CSC_S_DONE && cmp_s2_r) |=> $stable(cnt_r))
    else $error("count moved after stop");
  a_idle_run: assert property (@(posedge clk) disable iff (!rst_n)
    (en && state_r == csc_pkg::CSC_S_IDLE) |=> state_r == csc_pkg::CSC_S_RUN)
    else $error("enable did not start counting");
  a_ovf_clear: assert property (@(posedge clk) disable iff (!rst_n)
    !en |=> !ovf_r)
    else $error("overflow kept while disabled");
endmodule // cap_sense_counters

// ===== csc_cmp_model.sv
`timescale 1ns/1ns
// Comparator front end; its output moves on the falling edge of clk, half a cycle before the next rising sampling edge.
module csc_cmp_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Requested level and comparator output.
  input wire logic want,
  output logic cmp
);
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp <= 1'b0;
    end else begin
      cmp <= want;
    end
  end
endmodule // csc_cmp_model

// ===== csc_params.svh
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH
`define CSC_OFF_CTRL 12'h000
`define CSC_OFF_CFG 12'h004
`define CSC_OFF_TIMER 12'h008
`define CSC_OFF_RESULT 12'h00c
`define CSC_OFF_STATUS 12'h010
`define CSC_OFF_MASK 12'h014
`define CSC_OFF_PRS 12'h018
`define CSC_CTRL_EN 0
`define CSC_CTRL_MODE_LO 1
`define CSC_CTRL_SD 3
`define CSC_ST_DONE 0
`define CSC_ST_OVF 1
`define CSC_ST_TC 2
`define CSC_CTRL_RST 8'h00
`define CSC_CFG_RST 8'h00
`define CSC_TIMER_RST 6'h3f
`define CSC_MASK_RST 3'h0
`define CSC_PRS8_SEED 8'hff
`define CSC_PRS12_SEED 12'hfff
`define CSC_PRS8_TAPS 8'hb8
`define CSC_PRS12_TAPS 12'he08
`endif

// ===== csc_pkg.sv
package csc_pkg;
  typedef enum logic [1:0] {
    CSC_M_CHARGE,
    CSC_M_RELAX1,
    CSC_M_RELAX2,
    CSC_M_SUCCAPP
  } csc_mode_t;
  typedef enum logic [1:0] {
    CSC_S_IDLE,
    CSC_S_RUN,
    CSC_S_DONE
  } csc_state_t;
  typedef struct packed {
    logic cmp;
    logic relax;
    logic start;
  } csc_sense_t;
endpackage

// ===== csc_prescaler.sv
`timescale 1ns/1ns
// Divides the system clock by 2**sel, at most 256 for sel above 8, and emits one tick per divided period.
module csc_prescaler #(
  parameter int SEL_W = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control.
  input wire logic [SEL_W-1:0] sel,
  // Output.
  output logic tick
);
  logic [7:0] div_r;
  logic [7:0] mask;

  always_comb begin
    mask = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(sel)) begin
        mask[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  assign tick = ((div_r & mask) == 8'h00);
endmodule // csc_prescaler

// ===== tb_top.sv
`timescale 1ns/1ns
`include "csc_params.svh"
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic start_r = 1'b0;
  logic relax_r = 1'b0;
  logic want = 1'b1;
  logic cmp_w;
  logic prs_out;
  logic irq;
  csc_pkg::csc_sense_t sense;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int n_tests = 0;
  integer seed = 32'hbede;
  int n;
  int l;
  assign sense = {cmp_w, relax_r, start_r};
  always #2 clk = ~clk;
  always @(posedge clk) relax_r <= 1'($random(seed));
  cap_sense_counters dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense(sense), .prs_out(prs_out), .irq(irq));
  csc_cmp_model cmp_model (.clk(clk), .rst_n(rst_n), .want(want), .cmp(cmp_w));
  // The trip reaches the counter two edges late, and the first enabled edge only arms it.
  function automatic int charge_exp(input int k);
    charge_exp = k + 1;
  endfunction
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Runs one sigma-delta interval of nc cycles with the comparator low for lc of them.
  task automatic measure(input int nc, input int lc);
    want <= 1'b1;
    apb(1'b1, `CSC_OFF_CTRL, 32'h0);
    apb(1'b1, `CSC_OFF_CTRL, 32'h9);
    repeat (4) @(posedge clk);
    start_r <= 1'b1;
    repeat (3) @(posedge clk);
    if (lc > 0) begin
      want <= 1'b0;
      repeat (lc) @(posedge clk);
      want <= 1'b1;
    end
    repeat (nc - 3 - lc) @(posedge clk);
    start_r <= 1'b0;
    repeat (2) @(posedge clk);
    want <= 1'b0;
    repeat (3) @(posedge clk);
    want <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `CSC_OFF_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `CSC_OFF_TIMER, 32'h0);
    check(rd, 32'h3f);
    apb(1'b0, `CSC_OFF_MASK, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 12'h040, 32'h5);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h040, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    $display("test registers done");
    apb(1'b1, `CSC_OFF_CTRL, 32'h8);
    start_r <= 1'b1;
    repeat (10) @(posedge clk);
    start_r <= 1'b0;
    apb(1'b0, `CSC_OFF_RESULT, 32'h0);
    check(rd & 32'hffff, 32'h0);
    $display("test enable gate done");
    for (int i = 0; i < 5; i++) begin
      n = (i == 0) ? 8 : (i == 1) ? 511 : 20 + ($random(seed) & 31);
      l = (i == 0) ? 0 : 1 + ($random(seed) & 7);
      measure(n, l);
      apb(1'b0, `CSC_OFF_RESULT, 32'h0);
      check(rd & 32'hffff, n - l);
      apb(1'b0, `CSC_OFF_STATUS, 32'h0);
      check(rd & 32'h1, 32'h1);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, `CSC_OFF_MASK, 32'h1);
      @(posedge clk);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, `CSC_OFF_STATUS, 32'h1);
      @(posedge clk);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, `CSC_OFF_MASK, 32'h0);
      $display("test measure %0d done", i);
    end
    apb(1'b1, `CSC_OFF_CTRL, 32'h0);
    want <= 1'b0;
    repeat (4) @(posedge clk);
    n = 3 + ($random(seed) & 15);
    apb(1'b1, `CSC_OFF_CTRL, 32'h1);
    repeat (n) @(posedge clk);
    want <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b0, `CSC_OFF_RESULT, 32'h0);
    check(rd & 32'hffff, charge_exp(n));
    $display("test charge done");
    apb(1'b1, `CSC_OFF_CTRL, 32'h0);
    apb(1'b1, `CSC_OFF_STATUS, 32'h7);
    apb(1'b1, `CSC_OFF_TIMER, 32'h5);
    apb(1'b1, `CSC_OFF_CTRL, 32'h7);
    apb(1'b0, `CSC_OFF_STATUS, 32'h0);
    check(rd & 32'h4, 32'h0);
    repeat (12) @(posedge clk);
    apb(1'b0, `CSC_OFF_STATUS, 32'h0);
    check(rd & 32'h4, 32'h4);
    $display("test timer done");
    apb(1'b1, `CSC_OFF_CTRL, 32'h0);
    n = 0;
    repeat (255) begin
      @(negedge clk);
      n += prs_out;
    end
    check(n, 32'd128);
    $display("test sequence done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `CSC_OFF_TIMER, 32'h0);
    check(rd, 32'h3f);
    $display("test reset done");
    give_verdict();
  end
endmodule // tb_top
